// ==== src/rsc_consts.svh ====
// Constants for the speed-selection control block.
`ifndef RSC_CONSTS_SVH
`define RSC_CONSTS_SVH
`define RSC_ADDR_W 8
`define RSC_DATA_W 8
`define RSC_TAG_ADDR 8'h0d
`define RSC_SOFT_ADDR 8'h6e
`define RSC_SOFT_BIT 3
`define RSC_TAG_FC_BIT 0
`define RSC_TAG_COUNT 8
`define RSC_TAG_VALUE 8'h01
`define RSC_TAG_RSVD_MASK 8'hfe
`define RSC_SOFT_RESET 1'b0
`define RSC_RD_IDLE 8'h00
`define RSC_PAGE_ID 1'b0
`define RSC_PAGE_DIAG 1'b1
`endif

// ==== src/rsc_pkg.sv ====
// Types shared by the speed-selection control block.
package rsc_pkg;
  typedef enum logic [1:0] {
    RSC_RATE_LOW = 2'b01,
    RSC_RATE_HIGH = 2'b10
  } rsc_rate_t;
  typedef logic [7:0] rsc_byte_t;
endpackage : rsc_pkg

// ==== src/rsc_sync2.sv ====
// Two-stage synchroniser for a level arriving from a pin.
`timescale 1ns/100ps
module rsc_sync2 (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic d,
  output logic q
);
  logic meta_ff;

  // The first stage feeds only the second stage.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_ff <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule : rsc_sync2

// ==== src/rsc_top.sv ====
// Speed-selection control: pin and software speed bit, compliance tag byte.
`timescale 1ns/100ps
`include "rsc_consts.svh"
module rsc_top (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic speed_pin,
  input wire logic mgmt_page,
  input wire logic [`RSC_ADDR_W-1:0] mgmt_addr,
  input wire logic mgmt_wr_stb,
  input wire rsc_pkg::rsc_byte_t mgmt_wr_data,
  input wire logic mgmt_rd_stb,
  output rsc_pkg::rsc_byte_t mgmt_rd_data,
  output logic mgmt_rd_valid,
  output logic rx_rate_high,
  output rsc_pkg::rsc_rate_t rx_rate_state,
  output logic legacy_mode
);
  import rsc_pkg::*;

  // Typed copy of the tag byte so each position is picked out by index, not by a shift.
  localparam rsc_byte_t tag_word = `RSC_TAG_VALUE;

  logic pin_sync;
  logic soft_speed_ff;
  logic nxt_soft_speed;
  rsc_rate_t rate_ff;
  rsc_rate_t nxt_rate;
  rsc_byte_t rd_data_ff;
  rsc_byte_t nxt_rd_data;
  logic rd_valid_ff;
  logic rx_high_ff;
  logic legacy_ff;
  logic [`RSC_TAG_COUNT-1:0] tag_bits;
  logic hit_tag;
  logic hit_soft;

  // The pin comes from the host and is asynchronous to this clock.
  rsc_sync2 u_pin_sync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .d(speed_pin),
    .q(pin_sync)
  );

  // Each tag is a fixed bit; reserved positions are forced to zero so a
  // later edit of the tag value cannot advertise an undefined grouping.
  genvar gi;
  generate
    for (gi = 0; gi < `RSC_TAG_COUNT; gi = gi + 1) begin : g_tag
      if (gi == `RSC_TAG_FC_BIT) begin : g_fc
        assign tag_bits[gi] = tag_word[gi];
      end else begin : g_rsvd
        assign tag_bits[gi] = 1'b0;
      end
    end
  endgenerate

  assign hit_tag = (mgmt_page == `RSC_PAGE_ID) && (mgmt_addr == `RSC_TAG_ADDR);
  assign hit_soft = (mgmt_page == `RSC_PAGE_DIAG) && (mgmt_addr == `RSC_SOFT_ADDR);

  // Software speed bit; the ID page has no writable storage at all.
  always_comb begin
    nxt_soft_speed = soft_speed_ff;
    if (mgmt_wr_stb && hit_soft) begin
      nxt_soft_speed = mgmt_wr_data[`RSC_SOFT_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      soft_speed_ff <= `RSC_SOFT_RESET;
    end else begin
      soft_speed_ff <= nxt_soft_speed;
    end
  end

  // Effective choice; the same two-state behaviour applies whatever tags
  // are set, which keeps legacy hosts working unchanged.
  always_comb begin
    if (pin_sync || soft_speed_ff) begin
      nxt_rate = RSC_RATE_HIGH;
    end else begin
      nxt_rate = RSC_RATE_LOW;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rate_ff <= RSC_RATE_LOW;
      rx_high_ff <= 1'b0;
    end else begin
      rate_ff <= nxt_rate;
      rx_high_ff <= (nxt_rate == RSC_RATE_HIGH);
    end
  end

  // Legacy flag shows that no extended grouping is advertised.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      legacy_ff <= 1'b0;
    end else begin
      legacy_ff <= (tag_bits == '0);
    end
  end

  // Register read path: one cycle from strobe to data; unmapped reads give zero.
  always_comb begin
    nxt_rd_data = `RSC_RD_IDLE;
    case (1'b1)
      hit_tag: begin
        nxt_rd_data = tag_bits;
      end
      hit_soft: begin
        nxt_rd_data[`RSC_SOFT_BIT] = soft_speed_ff;
      end
      default: begin
        nxt_rd_data = `RSC_RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_ff <= `RSC_RD_IDLE;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_valid_ff <= mgmt_rd_stb;
      if (mgmt_rd_stb) begin
        rd_data_ff <= nxt_rd_data;
      end
    end
  end

  assign mgmt_rd_data = rd_data_ff;
  assign mgmt_rd_valid = rd_valid_ff;
  assign rx_rate_high = rx_high_ff;
  assign rx_rate_state = rate_ff;
  assign legacy_mode = legacy_ff;

  // Checks.
  property p_or_high;
    @(posedge core_clk) disable iff (!reset_n)
    (pin_sync || soft_speed_ff) |=> rx_rate_high;
  endproperty
  a_or_high: assert property (p_or_high)
    else $error("Receiver rate not high while pin or soft bit set.");

  property p_both_low;
    @(posedge core_clk) disable iff (!reset_n)
    (!pin_sync && !soft_speed_ff) |=> (rx_rate_state == RSC_RATE_LOW) && !rx_rate_high;
  endproperty
  a_both_low: assert property (p_both_low)
    else $error("Receiver rate not low while both inputs low.");

  property p_soft_write;
    @(posedge core_clk) disable iff (!reset_n)
    (mgmt_wr_stb && hit_soft) |=> (soft_speed_ff == $past(mgmt_wr_data[`RSC_SOFT_BIT]));
  endproperty
  a_soft_write: assert property (p_soft_write)
    else $error("Software speed bit did not take the written value.");

  property p_soft_to_rate;
    @(posedge core_clk) disable iff (!reset_n)
    (mgmt_wr_stb && hit_soft && mgmt_wr_data[`RSC_SOFT_BIT]) |=> ##1 rx_rate_high;
  endproperty
  a_soft_to_rate: assert property (p_soft_to_rate)
    else $error("Soft bit write did not raise receiver rate in two cycles.");

  property p_pin_path;
    @(posedge core_clk) disable iff (!reset_n)
    (speed_pin && !soft_speed_ff) [*4] |-> rx_rate_high;
  endproperty
  a_pin_path: assert property (p_pin_path)
    else $error("Steady high pin did not raise receiver rate.");

  property p_tag_read;
    @(posedge core_clk) disable iff (!reset_n)
    (mgmt_rd_stb && hit_tag) |=> mgmt_rd_valid && (mgmt_rd_data == `RSC_TAG_VALUE);
  endproperty
  a_tag_read: assert property (p_tag_read)
    else $error("Tag byte read returned wrong value.");

  property p_rsvd_zero;
    @(posedge core_clk) disable iff (!reset_n)
    (mgmt_rd_stb && hit_tag) |=> ((mgmt_rd_data & `RSC_TAG_RSVD_MASK) == 8'h00);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("Reserved tag bits read nonzero.");

  property p_id_ro;
    @(posedge core_clk) disable iff (!reset_n)
    (mgmt_wr_stb && hit_tag) ##2 (mgmt_rd_stb && hit_tag)
      |=> (mgmt_rd_data == `RSC_TAG_VALUE) && $stable(soft_speed_ff);
  endproperty
  a_id_ro: assert property (p_id_ro)
    else $error("Write to read-only page changed state.");

  property p_soft_hold;
    @(posedge core_clk) disable iff (!reset_n)
    !(mgmt_wr_stb && hit_soft) |=> $stable(soft_speed_ff);
  endproperty
  a_soft_hold: assert property (p_soft_hold)
    else $error("Software speed bit changed without a write.");

  property p_legacy;
    @(posedge core_clk) disable iff (!reset_n)
    $rose(reset_n) ##1 1'b1 |-> (legacy_mode == (`RSC_TAG_VALUE == 8'h00));
  endproperty
  a_legacy: assert property (p_legacy)
    else $error("Legacy flag disagrees with tag byte.");

  property p_state_pair;
    @(posedge core_clk) disable iff (!reset_n)
    ##1 (rx_rate_high == (rx_rate_state == RSC_RATE_HIGH));
  endproperty
  a_state_pair: assert property (p_state_pair)
    else $error("Receiver rate flag and state disagree.");

  property p_rd_quiet;
    @(posedge core_clk) disable iff (!reset_n)
    !mgmt_rd_stb |=> !mgmt_rd_valid;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet)
    else $error("Read valid raised without a read request.");

  property p_state_onehot;
    @(posedge core_clk) disable iff (!reset_n)
    $onehot(rx_rate_state);
  endproperty
  a_state_onehot: assert property (p_state_onehot)
    else $error("Receiver rate state is not a legal one-hot code.");
endmodule : rsc_top

// ==== test/rsc_host.sv ====
// Host model: drives the speed pin and the management byte port.
`timescale 1ns/100ps
module rsc_host (
  input wire logic core_clk,
  input wire rsc_pkg::rsc_byte_t mgmt_rd_data,
  input wire logic mgmt_rd_valid,
  output logic speed_pin,
  output logic mgmt_page,
  output logic [7:0] mgmt_addr,
  output logic mgmt_wr_stb,
  output rsc_pkg::rsc_byte_t mgmt_wr_data,
  output logic mgmt_rd_stb
);
  import rsc_pkg::*;
  initial begin
    speed_pin = 1'b0;
    mgmt_page = 1'b0;
    mgmt_addr = 8'h00;
    mgmt_wr_stb = 1'b0;
    mgmt_wr_data = 8'h00;
    mgmt_rd_stb = 1'b0;
  end
  // Speed changes go through the pin, one cycle slower than a soft bit write (three edges against two).
  task automatic set_pin(input logic v);
    speed_pin = v;
  endtask : set_pin
  // Released address and data lines are inverted so stale values cannot pass by luck.
  task automatic wr(input logic page, input logic [7:0] addr, input rsc_byte_t data);
    mgmt_page = page;
    mgmt_addr = addr;
    mgmt_wr_data = data;
    mgmt_wr_stb = 1'b1;
    @(posedge core_clk);
    #1;
    mgmt_wr_stb = 1'b0;
    mgmt_addr = ~addr;
    mgmt_wr_data = ~data;
    // One idle edge, so a following call never reassigns these lines in this step.
    @(posedge core_clk);
    #1;
  endtask : wr
  task automatic rd(input logic page, input logic [7:0] addr, output rsc_byte_t data,
                    output logic valid);
    mgmt_page = page;
    mgmt_addr = addr;
    mgmt_rd_stb = 1'b1;
    @(posedge core_clk);
    #1;
    mgmt_rd_stb = 1'b0;
    mgmt_addr = ~addr;
    data = mgmt_rd_data;
    valid = mgmt_rd_valid;
    @(posedge core_clk);
    #1;
  endtask : rd
endmodule : rsc_host

// ==== test/rate_select_control_bench.sv ====
// Self-checking bench for the speed-selection control block.
`timescale 1ns/100ps
module rate_select_control_bench;
  import rsc_pkg::*;
  logic core_clk, reset_n, speed_pin, mgmt_page, mgmt_wr_stb, mgmt_rd_stb;
  logic mgmt_rd_valid, rx_rate_high, legacy_mode;
  logic [7:0] mgmt_addr;
  rsc_byte_t mgmt_wr_data, mgmt_rd_data;
  rsc_rate_t rx_rate_state;
  int err_total = 0;
  int checked = 0;
  rsc_top u_rsc_top (.core_clk(core_clk), .reset_n(reset_n), .speed_pin(speed_pin),
    .mgmt_page(mgmt_page), .mgmt_addr(mgmt_addr), .mgmt_wr_stb(mgmt_wr_stb),
    .mgmt_wr_data(mgmt_wr_data), .mgmt_rd_stb(mgmt_rd_stb), .mgmt_rd_data(mgmt_rd_data),
    .mgmt_rd_valid(mgmt_rd_valid), .rx_rate_high(rx_rate_high),
    .rx_rate_state(rx_rate_state), .legacy_mode(legacy_mode));
  rsc_host u_rsc_host (.core_clk(core_clk), .mgmt_rd_data(mgmt_rd_data),
    .mgmt_rd_valid(mgmt_rd_valid), .speed_pin(speed_pin), .mgmt_page(mgmt_page),
    .mgmt_addr(mgmt_addr), .mgmt_wr_stb(mgmt_wr_stb), .mgmt_wr_data(mgmt_wr_data),
    .mgmt_rd_stb(mgmt_rd_stb));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_rate(input logic hi);
    chk({7'h00, rx_rate_high}, {7'h00, hi});
    chk({6'h00, rx_rate_state}, hi ? {6'h00, RSC_RATE_HIGH} : {6'h00, RSC_RATE_LOW});
  endtask : chk_rate
  task automatic rd(input logic page, input logic [7:0] addr, input logic [7:0] exp);
    rsc_byte_t got;
    logic vld;
    u_rsc_host.rd(page, addr, got, vld);
    chk({7'h00, vld}, 8'h01);
    chk(got, exp);
  endtask : rd
  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    repeat (3000) @(posedge core_clk);
    err_total++;
    summarize();
  end
  initial begin
    reset_n = 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    chk_rate(1'b0);
    chk({7'h00, mgmt_rd_valid}, 8'h00);
    reset_n = 1'b1;
    @(posedge core_clk);
    #1;
    chk({7'h00, legacy_mode}, 8'h00);
    rd(1'b1, 8'h6e, 8'h00);
    $display("test reset done");
    rd(1'b0, 8'h0d, 8'h01);
    @(posedge core_clk);
    #1;
    chk({7'h00, mgmt_rd_valid}, 8'h00);
    chk(mgmt_rd_data, 8'h01);
    u_rsc_host.wr(1'b0, 8'h0d, 8'hfe);
    rd(1'b0, 8'h0d, 8'h01);
    rd(1'b1, 8'h00, 8'h00);
    $display("test tag byte done");
    // Pin path is exactly two sync stages plus the output register.
    u_rsc_host.set_pin(1'b1);
    repeat (2) @(posedge core_clk);
    #1;
    chk_rate(1'b0);
    @(posedge core_clk);
    #1;
    chk_rate(1'b1);
    u_rsc_host.wr(1'b1, 8'h6e, 8'hf7);
    rd(1'b1, 8'h6e, 8'h00);
    for (int i = 0; i < 4; i++) begin
      u_rsc_host.set_pin(i[1]);
      u_rsc_host.wr(1'b1, 8'h6e, i[0] ? 8'h08 : 8'h00);
      repeat (3) @(posedge core_clk);
      #1;
      chk_rate(i[1] | i[0]);
      rd(1'b1, 8'h6e, {4'h0, i[0], 3'h0});
    end
    $display("test speed choice done");
    // The last pass left the soft bit high; a second reset must clear it.
    u_rsc_host.set_pin(1'b0);
    reset_n = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    chk_rate(1'b0);
    reset_n = 1'b1;
    @(posedge core_clk);
    #1;
    rd(1'b1, 8'h6e, 8'h00);
    repeat (2) @(posedge core_clk);
    #1;
    chk_rate(1'b0);
    chk({7'h00, legacy_mode}, 8'h00);
    $display("test second reset done");
    summarize();
  end
endmodule : rate_select_control_bench
